// file: hw/rtc_map.vh
// Purpose: register map, field positions, reset values and timing counts of the
//          calendar, alarm, frequency output and countdown timer block
// Assumes: 4-bit word address, 8-bit registers
// Notes:   definitions only
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// word addresses
`define RTC_ADDR_CTRL2         4'h1
`define RTC_ADDR_MONTH_CENTURY 4'h7
`define RTC_ADDR_YEAR_COUNT    4'h8
`define RTC_ADDR_MINUTE_ALARM  4'h9
`define RTC_ADDR_HOUR_ALARM    4'hA
`define RTC_ADDR_DAY_ALARM     4'hB
`define RTC_ADDR_WEEKDAY_ALARM 4'hC
`define RTC_ADDR_FREQ_OUT_CTRL 4'hD
`define RTC_ADDR_CNTDN_CTRL    4'hE
`define RTC_ADDR_CNTDN_VALUE   4'hF

// control/status 2 fields
`define RTC_BIT_ALARM_FLAG     3
`define RTC_BIT_CNTDN_FLAG     2
`define RTC_BIT_ALARM_IRQ_EN   1
`define RTC_BIT_CNTDN_IRQ_EN   0

// shared field positions
`define RTC_BIT_CENTURY        7
`define RTC_BIT_FIELD_DISABLE  7
`define RTC_BIT_FREQ_ON        7
`define RTC_BIT_CNTDN_RUN      7

// frequency select codes
`define RTC_FREQ_32768         2'h0
`define RTC_FREQ_1024          2'h1
`define RTC_FREQ_32            2'h2
`define RTC_FREQ_1             2'h3

// countdown source codes
`define RTC_SRC_4096           2'h0
`define RTC_SRC_64             2'h1
`define RTC_SRC_1              2'h2
`define RTC_SRC_1_60           2'h3

// weekday codes
`define RTC_WD_THURSDAY        3'h4
`define RTC_WD_FRIDAY          3'h5
`define RTC_WD_SATURDAY        3'h6

// reset values
`define RTC_RST_MONTH_CENTURY  8'h01
`define RTC_RST_YEAR_COUNT     8'h00
`define RTC_RST_ALARM          8'h80
`define RTC_RST_FREQ_OUT_CTRL  8'h80
`define RTC_RST_CNTDN_CTRL     8'h03
`define RTC_RST_CNTDN_VALUE    8'h00

// bcd limits
`define RTC_MONTH_FIRST        5'h01
`define RTC_MONTH_LAST         5'h12
`define RTC_YEAR_LAST          8'h99

// oscillator divider taps, in oscillator edges
`define RTC_PRE_WIDTH          15
`define RTC_TAP_1024           4
`define RTC_TAP_32             9
`define RTC_TAP_1              14
`define RTC_MASK_4096          15'h0007
`define RTC_MASK_64            15'h01FF
`define RTC_MASK_1             15'h7FFF
`define RTC_SECONDS_PER_MINUTE 6'h3B

`endif

// file: hw/rtc_prescale.v
// Purpose: synchronise the 32.768 kHz oscillator and derive taps and ticks
// Assumes: core_clk well above twice the oscillator rate
// Notes:   ticks are one core_clk pulses on oscillator rising edges
`timescale 1ns/1ps
`include "rtc_map.vh"
`default_nettype none

module rtc_prescale
(
    // clock and reset
    input wire core_clk,
    input wire reset,
    // oscillator
    input wire osc_clk,
    // derived
    output reg osc_level_reg,
    output reg [`RTC_PRE_WIDTH-1:0] div_reg,
    output reg tick_4096_reg,
    output reg tick_64_reg,
    output reg tick_1_reg
);

reg osc_meta_reg;
reg osc_sync_reg;
wire osc_rise;

assign osc_rise = osc_sync_reg & ~osc_level_reg;

////////////////////////////////////////////////////////////////////////////////
always @(posedge core_clk)
begin
    if (reset)
    begin
        osc_meta_reg <= 1'b0;
        osc_sync_reg <= 1'b0;
        osc_level_reg <= 1'b0;
        div_reg <= {`RTC_PRE_WIDTH{1'b0}};
        tick_4096_reg <= 1'b0;
        tick_64_reg <= 1'b0;
        tick_1_reg <= 1'b0;
    end
    else
    begin
        osc_meta_reg <= osc_clk;
        osc_sync_reg <= osc_meta_reg;
        osc_level_reg <= osc_sync_reg;
        if (osc_rise)
            div_reg <= div_reg + {{(`RTC_PRE_WIDTH-1){1'b0}}, 1'b1};
        tick_4096_reg <= osc_rise && ((div_reg & `RTC_MASK_4096) == `RTC_MASK_4096);
        tick_64_reg <= osc_rise && ((div_reg & `RTC_MASK_64) == `RTC_MASK_64);
        tick_1_reg <= osc_rise && (div_reg == `RTC_MASK_1);
    end
end

endmodule
`default_nettype wire

// file: hw/rtc_calendar_alarm_timer.v
// Purpose: month/century and year registers, alarm comparator, frequency
//          output and 8-bit countdown timer with flags and interrupt
// Assumes: register port driven by the serial slave on core_clk; minute,
//          hour, day and weekday counters live outside on core_clk
// Notes:   the oscillator is sampled, never used as a clock
`timescale 1ns/1ps
`include "rtc_map.vh"
`default_nettype none

// Operation
// - weekday codes sit in bits 2..0; Thursday 100, Friday 101, Saturday 110
// - century bit 7 toggles when the year rolls from 99 to 00
// - century bit 0 means years 20xx
// - century bit 1 means years 19xx
// - month is BCD 01..12 in bits 4..0
// - year is eight-bit BCD 00..99
// - enabled alarm fields compared; flag set when all first match
// - alarm flag stays set until software clears it
// - after clearing, flag sets only on a new match, not persisting one
// - alarm field with bit 7 set is excluded from comparison
// - minute alarm: BCD 00..59 in bits 6..0, disable in bit 7
// - hour alarm: BCD 00..23 in bits 5..0, disable in bit 7
// - day alarm: BCD 01..31 in bits 5..0, disable in bit 7
// - weekday alarm: code 0..6 in bits 2..0, disable in bit 7
// - output control bit 7 low floats the pin, high drives frequency
// - select 00 32.768 kHz, 01 1024 Hz, 10 32 Hz, 11 1 Hz
// - 8-bit down-counter runs only while timer control bit 7 is set
// - source 00 4096 Hz, 01 64 Hz, 10 1 Hz, 11 1/60 Hz
// - timer value 00..FF; period is n over source frequency
// - writing 0 clears alarm or timer flag, writing 1 keeps it
// - interrupt is OR of each flag gated by its enable
// - timer stays stopped while loaded value is zero
module rtc_calendar_alarm_timer
(
    // clock and reset
    input wire core_clk,
    input wire reset,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_reg,
    // oscillator
    input wire osc_clk,
    // current time from the lower counters
    input wire [6:0] cur_minute,
    input wire [5:0] cur_hour,
    input wire [5:0] cur_day,
    input wire [2:0] cur_weekday,
    input wire month_advance,
    // frequency output pin
    output reg freq_pin_out_reg,
    output wire freq_pin_oe_n,
    // interrupt pin, open drain
    output wire int_pin_out,
    output wire int_pin_oe_n,
    output wire irq
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// bcd increment with wrap to first above last
function [7:0] bcd_next;
    input [7:0] val;
    input [7:0] last;
    input [7:0] first;
    begin
        if (val >= last)
            bcd_next = first;
        else if (val[3:0] >= 4'h9)
            bcd_next = {val[7:4] + 4'h1, 4'h0};
        else
            bcd_next = {val[7:4], val[3:0] + 4'h1};
    end
endfunction

// a field counts as matching when disabled or equal
function field_ok;
    input [7:0] alarm;
    input [6:0] cur;
    input [6:0] mask;
    begin
        field_ok = alarm[`RTC_BIT_FIELD_DISABLE] | ((alarm[6:0] & mask) == (cur & mask));
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// declarations

reg [7:0] month_century_reg;
reg [7:0] year_count_reg;
reg [7:0] minute_alarm_reg;
reg [7:0] hour_alarm_reg;
reg [7:0] day_alarm_reg;
reg [7:0] weekday_alarm_reg;
reg [7:0] freq_output_control_reg;
reg [7:0] countdown_control_reg;
reg [7:0] countdown_load_reg;
reg [7:0] countdown_count_reg;
reg [5:0] sixty_reg;
reg alarm_flag_reg;
reg countdown_flag_reg;
reg alarm_irq_en_reg;
reg countdown_irq_en_reg;
reg alarm_match_reg;
reg [7:0] rdata_next;
reg freq_next;
reg src_tick;

wire osc_level;
wire [`RTC_PRE_WIDTH-1:0] div;
wire tick_4096;
wire tick_64;
wire tick_1;
wire tick_1_60;
wire wr_ctrl2;
wire wr_month;
wire wr_year;
wire wr_cnt_value;
wire any_enabled;
wire alarm_match;
wire alarm_rise;
wire countdown_run;
wire countdown_expire;
wire year_wrap;
wire [7:0] month_step;
wire [1:0] freq_sel;
wire [1:0] src_sel;

////////////////////////////////////////////////////////////////////////////////
// oscillator taps

rtc_prescale rtc_prescale_inst
(
    .core_clk(core_clk),
    .reset(reset),
    .osc_clk(osc_clk),
    .osc_level_reg(osc_level),
    .div_reg(div),
    .tick_4096_reg(tick_4096),
    .tick_64_reg(tick_64),
    .tick_1_reg(tick_1)
);

// minute tick for the slowest source
assign tick_1_60 = tick_1 && (sixty_reg == `RTC_SECONDS_PER_MINUTE);

always @(posedge core_clk)
begin
    if (reset)
        sixty_reg <= 6'h00;
    else if (tick_1)
        sixty_reg <= tick_1_60 ? 6'h00 : sixty_reg + 6'h01;
end

////////////////////////////////////////////////////////////////////////////////
// write decode

assign wr_ctrl2 = reg_wr && (reg_addr == `RTC_ADDR_CTRL2);
assign wr_month = reg_wr && (reg_addr == `RTC_ADDR_MONTH_CENTURY);
assign wr_year = reg_wr && (reg_addr == `RTC_ADDR_YEAR_COUNT);
assign wr_cnt_value = reg_wr && (reg_addr == `RTC_ADDR_CNTDN_VALUE);

always @(posedge core_clk)
begin
    if (reset)
    begin
        minute_alarm_reg <= `RTC_RST_ALARM;
        hour_alarm_reg <= `RTC_RST_ALARM;
        day_alarm_reg <= `RTC_RST_ALARM;
        weekday_alarm_reg <= `RTC_RST_ALARM;
        freq_output_control_reg <= `RTC_RST_FREQ_OUT_CTRL;
        countdown_control_reg <= `RTC_RST_CNTDN_CTRL;
        alarm_irq_en_reg <= 1'b0;
        countdown_irq_en_reg <= 1'b0;
    end
    else if (reg_wr)
    begin
        case (reg_addr)
            `RTC_ADDR_CTRL2:
            begin
                alarm_irq_en_reg <= reg_wdata[`RTC_BIT_ALARM_IRQ_EN];
                countdown_irq_en_reg <= reg_wdata[`RTC_BIT_CNTDN_IRQ_EN];
            end
            `RTC_ADDR_MINUTE_ALARM: minute_alarm_reg <= reg_wdata;
            `RTC_ADDR_HOUR_ALARM: hour_alarm_reg <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
            `RTC_ADDR_DAY_ALARM: day_alarm_reg <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
            `RTC_ADDR_WEEKDAY_ALARM: weekday_alarm_reg <= {reg_wdata[7], 4'h0, reg_wdata[2:0]};
            `RTC_ADDR_FREQ_OUT_CTRL: freq_output_control_reg <= {reg_wdata[7], 5'h00, reg_wdata[1:0]};
            `RTC_ADDR_CNTDN_CTRL: countdown_control_reg <= {reg_wdata[7], 5'h00, reg_wdata[1:0]};
            default:
            begin
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// month, century and year

// bit 7 = 0 reads as 20xx, 1 as 19xx; the block only toggles it
assign year_wrap = month_advance && (month_century_reg[4:0] >= `RTC_MONTH_LAST)
    && (year_count_reg >= `RTC_YEAR_LAST);
assign month_step = bcd_next({3'h0, month_century_reg[4:0]},
    {3'h0, `RTC_MONTH_LAST}, {3'h0, `RTC_MONTH_FIRST});

always @(posedge core_clk)
begin
    if (reset)
    begin
        month_century_reg <= `RTC_RST_MONTH_CENTURY;
        year_count_reg <= `RTC_RST_YEAR_COUNT;
    end
    else
    begin
        if (wr_month)
            month_century_reg <= {reg_wdata[7], 2'h0, reg_wdata[4:0]};
        else if (month_advance)
        begin
            month_century_reg[4:0] <= month_step[4:0];
            if (year_wrap)
                month_century_reg[`RTC_BIT_CENTURY] <= ~month_century_reg[`RTC_BIT_CENTURY];
        end
        if (wr_year)
            year_count_reg <= reg_wdata;
        else if (month_advance && (month_century_reg[4:0] >= `RTC_MONTH_LAST))
            year_count_reg <= bcd_next(year_count_reg, `RTC_YEAR_LAST, 8'h00);
    end
end

////////////////////////////////////////////////////////////////////////////////
// alarm

// with every field disabled nothing is compared and no alarm can fire
assign any_enabled = ~(minute_alarm_reg[7] & hour_alarm_reg[7] & day_alarm_reg[7]
    & weekday_alarm_reg[7]);
assign alarm_match = any_enabled
    && field_ok(minute_alarm_reg, cur_minute, 7'h7F)
    && field_ok(hour_alarm_reg, {1'b0, cur_hour}, 7'h3F)
    && field_ok(day_alarm_reg, {1'b0, cur_day}, 7'h3F)
    && field_ok(weekday_alarm_reg, {4'h0, cur_weekday}, 7'h07);
// only the entry into a match sets the flag, so a held match cannot re-arm
assign alarm_rise = alarm_match && !alarm_match_reg;

always @(posedge core_clk)
begin
    if (reset)
    begin
        alarm_match_reg <= 1'b0;
        alarm_flag_reg <= 1'b0;
    end
    else
    begin
        alarm_match_reg <= alarm_match;
        if (alarm_rise)
            alarm_flag_reg <= 1'b1;
        else if (wr_ctrl2 && !reg_wdata[`RTC_BIT_ALARM_FLAG])
            alarm_flag_reg <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// countdown timer

assign src_sel = countdown_control_reg[1:0];
assign countdown_run = countdown_control_reg[`RTC_BIT_CNTDN_RUN]
    && (countdown_load_reg != 8'h00);
assign countdown_expire = countdown_run && src_tick && (countdown_count_reg == 8'h01);

always @*
begin
    case (src_sel)
        `RTC_SRC_4096: src_tick = tick_4096;
        `RTC_SRC_64: src_tick = tick_64;
        `RTC_SRC_1: src_tick = tick_1;
        `RTC_SRC_1_60: src_tick = tick_1_60;
        default: src_tick = 1'b0;
    endcase
end

always @(posedge core_clk)
begin
    if (reset)
    begin
        countdown_load_reg <= `RTC_RST_CNTDN_VALUE;
        countdown_count_reg <= `RTC_RST_CNTDN_VALUE;
        countdown_flag_reg <= 1'b0;
    end
    else
    begin
        if (wr_cnt_value)
        begin
            countdown_load_reg <= reg_wdata;
            countdown_count_reg <= reg_wdata;
        end
        else if (countdown_expire)
            countdown_count_reg <= countdown_load_reg;
        else if (countdown_run && src_tick)
            countdown_count_reg <= countdown_count_reg - 8'h01;
        if (countdown_expire)
            countdown_flag_reg <= 1'b1;
        else if (wr_ctrl2 && !reg_wdata[`RTC_BIT_CNTDN_FLAG])
            countdown_flag_reg <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// frequency output

assign freq_sel = freq_output_control_reg[1:0];

always @*
begin
    case (freq_sel)
        `RTC_FREQ_32768: freq_next = osc_level;
        `RTC_FREQ_1024: freq_next = div[`RTC_TAP_1024];
        `RTC_FREQ_32: freq_next = div[`RTC_TAP_32];
        `RTC_FREQ_1: freq_next = div[`RTC_TAP_1];
        default: freq_next = 1'b0;
    endcase
end

always @(posedge core_clk)
begin
    if (reset)
        freq_pin_out_reg <= 1'b0;
    else
        freq_pin_out_reg <= freq_next;
end

// pin floats while the output is off
assign freq_pin_oe_n = ~freq_output_control_reg[`RTC_BIT_FREQ_ON];

////////////////////////////////////////////////////////////////////////////////
// interrupt

assign irq = (alarm_flag_reg & alarm_irq_en_reg)
    | (countdown_flag_reg & countdown_irq_en_reg);
assign int_pin_out = 1'b0;
assign int_pin_oe_n = ~irq;

////////////////////////////////////////////////////////////////////////////////
// read back

// a live count can change under a slow serial read; the master must clock fast
always @*
begin
    case (reg_addr)
        `RTC_ADDR_CTRL2:
            rdata_next = {4'h0, alarm_flag_reg, countdown_flag_reg,
                alarm_irq_en_reg, countdown_irq_en_reg};
        `RTC_ADDR_MONTH_CENTURY: rdata_next = month_century_reg;
        `RTC_ADDR_YEAR_COUNT: rdata_next = year_count_reg;
        `RTC_ADDR_MINUTE_ALARM: rdata_next = minute_alarm_reg;
        `RTC_ADDR_HOUR_ALARM: rdata_next = hour_alarm_reg;
        `RTC_ADDR_DAY_ALARM: rdata_next = day_alarm_reg;
        `RTC_ADDR_WEEKDAY_ALARM: rdata_next = weekday_alarm_reg;
        `RTC_ADDR_FREQ_OUT_CTRL: rdata_next = freq_output_control_reg;
        `RTC_ADDR_CNTDN_CTRL: rdata_next = countdown_control_reg;
        `RTC_ADDR_CNTDN_VALUE: rdata_next = countdown_count_reg;
        default: rdata_next = 8'h00;
    endcase
end

always @(posedge core_clk)
begin
    if (reset)
        reg_rdata_reg <= 8'h00;
    else if (reg_rd)
        reg_rdata_reg <= rdata_next;
end

endmodule
`default_nettype wire

// file: verification/rtc_cat_checker.sv
// Purpose: port checks of the calendar, alarm, output and timer block
// Assumes: register port on core_clk, synchronous active-high reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`include "rtc_map.vh"
`default_nettype none
module rtc_cat_checker
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_reg,
    // pins
    input wire logic freq_pin_oe_n,
    input wire logic int_pin_out,
    input wire logic int_pin_oe_n,
    input wire logic irq
);
    // last written interrupt enables, kept here to judge irq
    logic [1:0] en_reg;
    always @(posedge core_clk)
    begin
        if (reset)
            en_reg <= 2'h0;
        else if (reg_wr && reg_addr == `RTC_ADDR_CTRL2)
            en_reg <= reg_wdata[1:0];
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    property p_freq_oe;
        reg_wr && reg_addr == `RTC_ADDR_FREQ_OUT_CTRL
            |=> freq_pin_oe_n == !$past(reg_wdata[7]);
    endproperty
    a_freq_oe: assert property (p_freq_oe) else $error("frequency pin enable wrong");
    property p_int_pin;
        int_pin_oe_n == !irq && int_pin_out == 1'b0;
    endproperty
    a_int_pin: assert property (p_int_pin) else $error("interrupt pin wrong");
    property p_irq_en;
        irq |-> en_reg != 2'h0;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq without enable");
    property p_irq_off;
        reg_wr && reg_addr == `RTC_ADDR_CTRL2 && reg_wdata[1:0] == 2'h0 |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq after masking");
    property p_minute_rw;
        reg_wr && reg_addr == `RTC_ADDR_MINUTE_ALARM ##1 reg_rd
            && reg_addr == `RTC_ADDR_MINUTE_ALARM |=> reg_rdata_reg == $past(reg_wdata, 2);
    endproperty
    a_minute_rw: assert property (p_minute_rw) else $error("minute alarm readback");
    property p_wday_bits;
        reg_rd && reg_addr == `RTC_ADDR_WEEKDAY_ALARM |=> reg_rdata_reg[6:3] == 4'h0;
    endproperty
    a_wday_bits: assert property (p_wday_bits) else $error("weekday alarm bits");
    property p_month_bits;
        reg_rd && reg_addr == `RTC_ADDR_MONTH_CENTURY |=> reg_rdata_reg[6:5] == 2'h0;
    endproperty
    a_month_bits: assert property (p_month_bits) else $error("month bits");
    property p_cntdn_bits;
        reg_rd && reg_addr == `RTC_ADDR_CNTDN_CTRL |=> reg_rdata_reg[6:2] == 5'h00;
    endproperty
    a_cntdn_bits: assert property (p_cntdn_bits) else $error("timer control bits");
    property p_unmapped;
        reg_rd && (reg_addr == 4'h0 || (reg_addr >= 4'h2 && reg_addr <= 4'h6))
            |=> reg_rdata_reg == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rd_hold;
        !reg_rd |=> $stable(reg_rdata_reg);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind rtc_calendar_alarm_timer rtc_cat_checker rtc_cat_checker_inst
(
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
    .freq_pin_oe_n(freq_pin_oe_n), .int_pin_out(int_pin_out),
    .int_pin_oe_n(int_pin_oe_n), .irq(irq)
);
`default_nettype wire

// file: verification/rtc_time_model.sv
// Purpose: crystal and lower time counters seen by the block
// Assumes: bench loads the time and pulses month roll
// Notes: crystal runs free, phase unrelated to core_clk
`timescale 1ns/1ps
`default_nettype none
module rtc_time_model
(
    // clock
    input wire logic core_clk,
    // bench control
    input wire logic load,
    input wire logic [21:0] set_time,
    input wire logic bump,
    // towards the block
    output logic osc_clk,
    output logic [6:0] cur_minute,
    output logic [5:0] cur_hour,
    output logic [5:0] cur_day,
    output logic [2:0] cur_weekday,
    output logic month_advance
);
    initial
    begin
        osc_clk = 1'b0;
        #37;
        forever #200 osc_clk = ~osc_clk;
    end
    always @(posedge core_clk)
    begin
        month_advance <= bump;
        if (load)
            {cur_minute, cur_hour, cur_day, cur_weekday} <= set_time;
    end
endmodule
`default_nettype wire

// file: verification/rtc_calendar_alarm_timer_test.sv
// Purpose: register-level tests of calendar, alarm, output and timer
// Assumes: strobes driven 2 ns after the rising edge
// Notes: osc at 400 ns gives 8 core cycles per oscillator period
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_timer_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic load = 1'b0;
    logic bump = 1'b0;
    logic [21:0] set_time = 22'h0;
    wire logic [7:0] reg_rdata_reg;
    wire logic osc_clk, month_advance, freq_pin_out_reg, freq_pin_oe_n, irq;
    wire logic [6:0] cur_minute;
    wire logic [5:0] cur_hour, cur_day;
    wire logic [2:0] cur_weekday;
    int mismatches = 0;
    int samples_checked = 0;
    int n;
    logic [7:0] v;
    localparam logic [7:0] RV [7:15] = '{8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
        8'h03, 8'h00};
    localparam logic [7:0] MV [7:15] = '{8'h9F, 8'hFF, 8'hFF, 8'hBF, 8'hBF, 8'h87, 8'h83,
        8'h83, 8'hFF};
    localparam int PER [0:3] = '{64, 4096, 0, 0};
    always #25 core_clk = ~core_clk;
    rtc_calendar_alarm_timer rtc_calendar_alarm_timer_inst
    (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg), .osc_clk(osc_clk),
        .cur_minute(cur_minute), .cur_hour(cur_hour), .cur_day(cur_day),
        .cur_weekday(cur_weekday), .month_advance(month_advance),
        .freq_pin_out_reg(freq_pin_out_reg), .freq_pin_oe_n(freq_pin_oe_n),
        .int_pin_out(), .int_pin_oe_n(), .irq(irq)
    );
    rtc_time_model rtc_time_model_inst
    (
        .core_clk(core_clk), .load(load), .set_time(set_time), .bump(bump),
        .osc_clk(osc_clk), .cur_minute(cur_minute), .cur_hour(cur_hour),
        .cur_day(cur_day), .cur_weekday(cur_weekday), .month_advance(month_advance)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobes stay up until the next call, so back-to-back accesses need no gap
    task automatic go(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #2;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        go(1'b1, 1'b0, a, d);
    endtask
    task automatic rdm(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        go(1'b0, 1'b1, a, 8'h00);
        chk(reg_rdata_reg & m, e);
    endtask
    task automatic cyc(input int k);
        repeat (k) go(1'b0, 1'b0, reg_addr, reg_wdata);
    endtask
    task automatic settime(input logic [6:0] mi, input logic [2:0] wd);
        set_time = {mi, 6'h00, 6'h01, wd};
        load = 1'b1;
        cyc(1);
        load = 1'b0;
        cyc(1);
    endtask
    task automatic bump_month;
        bump = 1'b1;
        cyc(1);
        bump = 1'b0;
        cyc(2);
    endtask
    task automatic toggles(input logic [1:0] s, input int lo, input int hi);
        logic p;
        int c;
        wr(4'hD, 8'h80 | s);
        cyc(2);
        c = 0;
        p = freq_pin_out_reg;
        repeat (8192)
        begin
            cyc(1);
            if (freq_pin_out_reg !== p)
                c++;
            p = freq_pin_out_reg;
        end
        chk({7'h0, freq_pin_oe_n}, 8'h00);
        chk({7'h0, c >= lo && c <= hi}, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #4000000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        repeat (10) @(posedge core_clk);
        #2;
        reset = 1'b0;
        rdm(4'h1, 8'hFF, 8'h00);
        for (int a = 7; a <= 15; a++)
            rdm(a[3:0], 8'hFF, RV[a]);
        for (int a = 7; a <= 15; a++)
        begin
            wr(a[3:0], 8'hFF);
            rdm(a[3:0], 8'hFF, MV[a]);
        end
        wr(4'h0, 8'hFF);
        rdm(4'h0, 8'hFF, 8'h00);
        for (int a = 9; a <= 14; a++)
            wr(a[3:0], RV[a]);
        // month and year roll
        wr(4'h7, 8'h12);
        wr(4'h8, 8'h99);
        bump_month();
        rdm(4'h7, 8'hFF, 8'h81);
        rdm(4'h8, 8'hFF, 8'h00);
        wr(4'h7, 8'h92);
        wr(4'h8, 8'h99);
        bump_month();
        rdm(4'h7, 8'hFF, 8'h01);
        wr(4'h7, 8'h09);
        bump_month();
        rdm(4'h7, 8'hFF, 8'h10);
        // alarm, all fields disabled never fires
        wr(4'h1, 8'h02);
        settime(7'h12, 3'h4);
        rdm(4'h1, 8'h08, 8'h00);
        for (int c = 4; c <= 6; c++)
        begin
            wr(4'hC, c[7:0]);
            settime(7'h12, 3'h0);
            wr(4'h1, 8'h02);
            settime(7'h12, c[2:0]);
            rdm(4'h1, 8'h08, 8'h08);
            chk({7'h0, irq}, 8'h01);
            wr(4'h1, 8'h0E);
            rdm(4'h1, 8'h08, 8'h08);
            wr(4'h1, 8'h02);
            cyc(3);
            rdm(4'h1, 8'h08, 8'h00);
        end
        wr(4'h9, 8'h30);
        settime(7'h12, 3'h0);
        settime(7'h12, 3'h6);
        rdm(4'h1, 8'h08, 8'h00);
        settime(7'h30, 3'h6);
        rdm(4'h1, 8'h08, 8'h08);
        // hour alarm off the current hour must block a fresh minute match
        wr(4'h1, 8'h02);
        wr(4'hA, 8'h05);
        settime(7'h31, 3'h6);
        settime(7'h30, 3'h6);
        rdm(4'h1, 8'h08, 8'h00);
        wr(4'hA, 8'h80);
        wr(4'h9, 8'h80);
        wr(4'hC, 8'h80);
        // frequency output
        wr(4'hD, 8'h00);
        cyc(1);
        chk({7'h0, freq_pin_oe_n}, 8'h01);
        toggles(2'h0, 2046, 2050);
        toggles(2'h1, 63, 65);
        toggles(2'h2, 1, 3);
        toggles(2'h3, 0, 1);
        // countdown, each source in turn
        for (int s = 0; s < 4; s++)
        begin
            wr(4'h1, 8'h01);
            wr(4'hE, 8'h00);
            wr(4'hF, 8'h02);
            wr(4'hE, 8'h80 | s);
            if (PER[s] == 0)
            begin
                cyc(5000);
                rdm(4'hF, 8'hFF, 8'h02);
            end
            else
            begin
                n = 0;
                v = 8'h02;
                while (v !== 8'h01 && n < 2 * PER[s])
                begin
                    go(1'b0, 1'b1, 4'hF, 8'h00);
                    v = reg_rdata_reg;
                    n++;
                end
                chk(v, 8'h01);
                cyc(PER[s] - 10);
                rdm(4'hF, 8'hFF, 8'h01);
                cyc(12);
                rdm(4'hF, 8'hFF, 8'h02);
                rdm(4'h1, 8'h04, 8'h04);
                chk({7'h0, irq}, 8'h01);
                wr(4'h1, 8'h0C);
                chk({7'h0, irq}, 8'h00);
            end
        end
        wr(4'hE, 8'h00);
        wr(4'hF, 8'h05);
        cyc(200);
        rdm(4'hF, 8'hFF, 8'h05);
        wr(4'h1, 8'h00);
        wr(4'hF, 8'h00);
        wr(4'hE, 8'h80);
        cyc(200);
        rdm(4'hF, 8'hFF, 8'h00);
        rdm(4'h1, 8'h04, 8'h00);
        wr(4'hE, 8'h03);
        cyc(2);
        complete_run();
    end
endmodule
`default_nettype wire
